/* sac_pkg.sv */
// Package for the slot A front-end configuration registers
package sac_pkg;

    // Register addresses on the control port
    localparam logic [7:0] SAC_ADDR_WINDOW = 8'h39;
    localparam logic [7:0] SAC_ADDR_FRONTEND = 8'h42;

    // Window timing register field layout
    localparam int SAC_WIDTH_MSB = 15;
    localparam int SAC_WIDTH_LSB = 11;
    localparam int SAC_OFFSET_MSB = 10;
    localparam int SAC_OFFSET_LSB = 0;
    localparam logic [4:0] SAC_WIDTH_RST = 5'h04;
    localparam logic [10:0] SAC_OFFSET_RST = 11'h2fc;

    // Step sizes of the window fields, in picoseconds
    localparam int SAC_WIDTH_STEP_PS = 1000000;
    localparam int SAC_OFFSET_STEP_PS = 31250;

    // Front-end control register field layout
    localparam int SAC_MODE_MSB = 15;
    localparam int SAC_MODE_LSB = 10;
    localparam int SAC_IGAIN_MSB = 9;
    localparam int SAC_IGAIN_LSB = 8;
    localparam int SAC_BUF_BIT = 7;
    localparam int SAC_INDEN_BIT = 6;
    localparam int SAC_VREF_MSB = 5;
    localparam int SAC_VREF_LSB = 4;
    localparam int SAC_CH1_MSB = 1;
    localparam int SAC_CH1_LSB = 0;
    localparam logic [5:0] SAC_MODE_RST = 6'h07;
    localparam logic [1:0] SAC_IGAIN_RST = 2'h0;
    localparam logic SAC_BUF_RST = 1'b0;
    localparam logic SAC_INDEN_RST = 1'b0;
    localparam logic [1:0] SAC_VREF_RST = 2'h3;
    localparam logic [1:0] SAC_CH1_RST = 2'h0;

    // Integrator gain codes
    typedef enum logic [1:0] {
        SAC_IG_400K = 2'b00,
        SAC_IG_200K = 2'b01,
        SAC_IG_100K = 2'b10,
        SAC_IG_RSVD = 2'b11
    } sac_igain_type;

    // Register access request from the serial control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } sac_req_type;

    // Settings handed to the analog front end
    typedef struct packed {
        logic [4:0] window_width;
        logic [10:0] window_offset;
        logic [5:0] frontend_mode;
        logic [1:0] int_resistor_code;
        logic buffer_mode;
        logic buffer_gain_low;
        logic [1:0] amp_reference_code;
        logic [7:0] chan_gain;
    } sac_cfg_type;

endpackage

/* sac_regs.sv */
// Slot A front-end configuration register bank and settings decode
// How it works
// - Window width bits 15:11, reset 4, counted in 1 us steps.
// - Window offset bits 10:0, reset 0x2FC, counted in 31.25 ns steps.
// - Normal mode: gain code 00/01/10 selects 400k/200k/100k resistor.
// - Buffer mode: gain codes 00 and 01 give buffer gain 1.0.
// - Buffer mode: gain code 10 gives buffer gain 0.7.
// - Bit 7 resets 0; set turns the integrator into a buffer.
// - Bit 6 set: channel 1 from bits 1:0, channels 2-4 from 0x55.
// - Reference code bits 5:4, reset 3; code 0 means 1.14 V.
`timescale 1ns/1ps
`default_nettype none

module sac_regs
    import sac_pkg::*;
(
    input wire logic i_clk,                  // System clock, 125 MHz
    input wire logic i_sys_rst,              // Async reset, active high
    input wire sac_req_type i_req,           // Access from control port
    input wire logic [5:0] i_ext_chan_gain,  // Channel 2-4 gains, reg 0x55
    output logic [15:0] o_rdata,             // Read data, registered
    output logic o_rvalid,                   // Read data valid pulse
    output sac_cfg_type o_cfg                // Decoded front-end settings
);

    // Register state
    logic [4:0] width_ff;
    logic [4:0] nxt_width;
    logic [10:0] offset_ff;
    logic [10:0] nxt_offset;
    logic [5:0] mode_ff;
    logic [5:0] nxt_mode;
    logic [1:0] igain_ff;
    logic [1:0] nxt_igain;
    logic buf_ff;
    logic nxt_buf;
    logic inden_ff;
    logic nxt_inden;
    logic [1:0] vref_ff;
    logic [1:0] nxt_vref;
    logic [1:0] ch1_ff;
    logic [1:0] nxt_ch1;

    // Read port state
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    // Output settings state
    sac_cfg_type cfg_ff;
    sac_cfg_type nxt_cfg;

    logic wr_window;
    logic wr_frontend;

    // Address decode shared by the write and read paths
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    // Read-back image of the window timing register
    function automatic logic [15:0] window_image(input logic [4:0] w,
                                                 input logic [10:0] o);
        window_image = {w, o};
    endfunction

    // Read-back image of the front-end control register; bits 3:2 read 0
    function automatic logic [15:0] frontend_image(input logic [5:0] m,
                                                   input logic [1:0] g,
                                                   input logic b,
                                                   input logic e,
                                                   input logic [1:0] v,
                                                   input logic [1:0] c);
        frontend_image = {m, g, b, e, v, 2'h0, c};
    endfunction

    assign wr_window = i_req.wr && addr_hit(i_req.addr, SAC_ADDR_WINDOW);
    assign wr_frontend = i_req.wr && addr_hit(i_req.addr, SAC_ADDR_FRONTEND);

    // Register writes
    always_comb
    begin
        nxt_width = width_ff;
        nxt_offset = offset_ff;
        nxt_mode = mode_ff;
        nxt_igain = igain_ff;
        nxt_buf = buf_ff;
        nxt_inden = inden_ff;
        nxt_vref = vref_ff;
        nxt_ch1 = ch1_ff;
        if (wr_window)
        begin
            nxt_width = i_req.wdata[SAC_WIDTH_MSB:SAC_WIDTH_LSB];
            nxt_offset = i_req.wdata[SAC_OFFSET_MSB:SAC_OFFSET_LSB];
        end
        if (wr_frontend)
        begin
            nxt_mode = i_req.wdata[SAC_MODE_MSB:SAC_MODE_LSB];
            nxt_igain = i_req.wdata[SAC_IGAIN_MSB:SAC_IGAIN_LSB];
            nxt_buf = i_req.wdata[SAC_BUF_BIT];
            nxt_inden = i_req.wdata[SAC_INDEN_BIT];
            nxt_vref = i_req.wdata[SAC_VREF_MSB:SAC_VREF_LSB];
            nxt_ch1 = i_req.wdata[SAC_CH1_MSB:SAC_CH1_LSB];
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            width_ff <= SAC_WIDTH_RST;
            offset_ff <= SAC_OFFSET_RST;
            mode_ff <= SAC_MODE_RST;
            igain_ff <= SAC_IGAIN_RST;
            buf_ff <= SAC_BUF_RST;
            inden_ff <= SAC_INDEN_RST;
            vref_ff <= SAC_VREF_RST;
            ch1_ff <= SAC_CH1_RST;
        end
        else
        begin
            width_ff <= nxt_width;
            offset_ff <= nxt_offset;
            mode_ff <= nxt_mode;
            igain_ff <= nxt_igain;
            buf_ff <= nxt_buf;
            inden_ff <= nxt_inden;
            vref_ff <= nxt_vref;
            ch1_ff <= nxt_ch1;
        end
    end

    // Read path; a read sees the value before a write in the same cycle
    always_comb
    begin
        nxt_rvalid = i_req.rd;
        nxt_rdata = rdata_ff;
        if (i_req.rd)
        begin
            if (addr_hit(i_req.addr, SAC_ADDR_WINDOW))
            begin
                nxt_rdata = window_image(width_ff, offset_ff);
            end
            else if (addr_hit(i_req.addr, SAC_ADDR_FRONTEND))
            begin
                nxt_rdata = frontend_image(mode_ff, igain_ff, buf_ff,
                                           inden_ff, vref_ff, ch1_ff);
            end
            else
            begin
                nxt_rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rdata_ff <= 16'h0000;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Settings decode; registered so the analog side sees glitch-free levels
    always_comb
    begin
        nxt_cfg.window_width = width_ff;
        nxt_cfg.window_offset = offset_ff;
        nxt_cfg.frontend_mode = mode_ff;
        nxt_cfg.amp_reference_code = vref_ff;
        nxt_cfg.buffer_mode = buf_ff;
        nxt_cfg.int_resistor_code = buf_ff ? SAC_IG_400K : igain_ff;
        nxt_cfg.buffer_gain_low = 1'b0;
        if (buf_ff)
        begin
            // buffer path relies on software setting bit 7
            case (sac_igain_type'(igain_ff))
                SAC_IG_400K, SAC_IG_200K: nxt_cfg.buffer_gain_low = 1'b0;
                SAC_IG_100K: nxt_cfg.buffer_gain_low = 1'b1;
                default: nxt_cfg.buffer_gain_low = 1'b0;
            endcase
        end
        if (inden_ff)
        begin
            nxt_cfg.chan_gain = {i_ext_chan_gain, ch1_ff};
        end
        else
        begin
            nxt_cfg.chan_gain = {4{ch1_ff}};
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cfg_ff.window_width <= SAC_WIDTH_RST;
            cfg_ff.window_offset <= SAC_OFFSET_RST;
            cfg_ff.frontend_mode <= SAC_MODE_RST;
            cfg_ff.int_resistor_code <= SAC_IGAIN_RST;
            cfg_ff.buffer_mode <= SAC_BUF_RST;
            cfg_ff.buffer_gain_low <= 1'b0;
            cfg_ff.amp_reference_code <= SAC_VREF_RST;
            cfg_ff.chan_gain <= {4{SAC_CH1_RST}};
        end
        else
        begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_rvalid = rvalid_ff;
    assign o_cfg = cfg_ff;

endmodule // sac_regs

`default_nettype wire

/* sac_regs_checker.sv */
// Assertion checker for the slot A front-end register bank
`timescale 1ns/1ps
`default_nettype none
module sac_regs_checker
    import sac_pkg::*;
(
    input wire logic i_clk, // System clock
    input wire logic i_sys_rst, // Async reset
    input wire sac_req_type i_req, // Register access
    input wire logic [5:0] i_ext_chan_gain, // Channel 2-4 gains
    input wire logic [15:0] o_rdata, // Read data
    input wire logic o_rvalid, // Read valid
    input wire sac_cfg_type o_cfg // Decoded settings
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_win_wr;
        i_req.wr && i_req.addr == SAC_ADDR_WINDOW;
    endsequence
    sequence s_ctl_wr;
        i_req.wr && i_req.addr == SAC_ADDR_FRONTEND;
    endsequence
    chk_read_strobe: assert property (
        i_req.rd |=> o_rvalid) else $error("read gave no valid");
    chk_valid_pulse: assert property (
        !i_req.rd |=> !o_rvalid) else $error("valid without read");
    // Settings lag the register by one edge, so both show one value here
    chk_window_read: assert property (
        i_req.rd && i_req.addr == SAC_ADDR_WINDOW |=>
        o_rdata == {o_cfg.window_width, o_cfg.window_offset})
        else $error("window read mismatch");
    chk_unmapped_read: assert property (
        i_req.rd && i_req.addr != SAC_ADDR_WINDOW &&
        i_req.addr != SAC_ADDR_FRONTEND |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_window_write: assert property (
        s_win_wr |-> ##2 {o_cfg.window_width, o_cfg.window_offset}
        == $past(i_req.wdata, 2)) else $error("window write lost");
    chk_buffer_gain: assert property (
        s_ctl_wr |-> ##2 o_cfg.buffer_mode == $past(i_req.wdata[7], 2) &&
        o_cfg.buffer_gain_low == ($past(i_req.wdata[7], 2) &&
        $past(i_req.wdata[9:8], 2) == 2'h2)) else $error("buffer decode");
    chk_resistor_code: assert property (
        s_ctl_wr |-> ##2 o_cfg.int_resistor_code ==
        ($past(i_req.wdata[7], 2) ? 2'h0 : $past(i_req.wdata[9:8], 2)))
        else $error("resistor code");
    chk_ctl_fields: assert property (
        s_ctl_wr |-> ##2 {o_cfg.frontend_mode, o_cfg.amp_reference_code}
        == {$past(i_req.wdata[15:10], 2), $past(i_req.wdata[5:4], 2)})
        else $error("mode or reference code");
    chk_window_hold: assert property (
        !i_req.wr |-> ##2 $stable({o_cfg.window_width, o_cfg.window_offset}))
        else $error("window changed without write");
    chk_ext_gain: assert property (
        s_ctl_wr ##0 i_req.wdata[6] |-> ##2 o_cfg.chan_gain ==
        {$past(i_ext_chan_gain), $past(i_req.wdata[1:0], 2)})
        else $error("channel gains");
endmodule // sac_regs_checker
bind sac_regs sac_regs_checker sac_regs_checker_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_req(i_req), .i_ext_chan_gain(i_ext_chan_gain),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cfg(o_cfg));
`default_nettype wire

/* test_sac_regs.sv */
// Self-checking testbench for the slot A front-end register bank
`timescale 1ns/1ps
`default_nettype none
module test_sac_regs
    import sac_pkg::*;
();
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    sac_req_type i_req = '0;
    logic [5:0] i_ext_chan_gain = 6'h00;
    logic [15:0] o_rdata;
    logic o_rvalid;
    sac_cfg_type o_cfg;
    int failures = 0;
    int checks_done = 0;
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] rd_exp;
        logic [15:0] view_exp;
    } sac_row_type;
    // buffer rows set bit 7
    // Buffer rows expect resistor code 00 in the settings view
    sac_row_type rows [9] = '{'{8'h39, 16'hffff, 16'hffff, 16'hffff},
        '{8'h39, 16'h0001, 16'h0001, 16'h0001},
        '{8'h42, 16'h1d30, 16'h1d30, 16'h1d30},
        '{8'h42, 16'h1e10, 16'h1e10, 16'h1e10},
        '{8'h42, 16'h1f00, 16'h1f00, 16'h1f00},
        '{8'h42, 16'h1c80, 16'h1c80, 16'h1c80},
        '{8'h42, 16'h1da0, 16'h1da0, 16'h1ca0},
        '{8'h42, 16'h1ef0, 16'h1ef0, 16'h1cf0},
        '{8'h42, 16'hffff, 16'hfff3, 16'hfcb0}};
    sac_regs sac_regs_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_req(i_req), .i_ext_chan_gain(i_ext_chan_gain),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_cfg(o_cfg));
    always #4 i_clk = ~i_clk;
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic w, input logic r, input logic [7:0] a,
        input logic [15:0] d);
        @(posedge i_clk);
        i_req <= '{wr: w, rd: r, addr: a, wdata: d};
    endtask
    function automatic logic [15:0] view(input logic [7:0] a);
        if (a == SAC_ADDR_WINDOW)
            return {o_cfg.window_width, o_cfg.window_offset};
        return {o_cfg.frontend_mode, o_cfg.int_resistor_code,
            o_cfg.buffer_mode, o_cfg.buffer_gain_low,
            o_cfg.amp_reference_code, 4'h0};
    endfunction
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        op(1'b0, 1'b1, a, 16'h0000);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk(o_rdata, exp);
        chk({15'h0000, o_rvalid}, 16'h0001);
    endtask
    task automatic reset_chk;
        rd_chk(SAC_ADDR_WINDOW, 16'h22fc);
        rd_chk(SAC_ADDR_FRONTEND, 16'h1c30);
        chk(view(SAC_ADDR_FRONTEND), 16'h1c30);
        chk({8'h00, o_cfg.chan_gain}, 16'h0000);
    endtask
    initial
    begin
        repeat (5000) @(posedge i_clk);
        failures++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        reset_chk();
        foreach (rows[i])
        begin
            op(1'b1, 1'b0, rows[i].addr, rows[i].wdata);
            rd_chk(rows[i].addr, rows[i].rd_exp);
            chk(view(rows[i].addr), rows[i].view_exp);
        end
        // Back to back, read beside write sees the old word
        op(1'b1, 1'b0, SAC_ADDR_WINDOW, 16'h5a5a);
        op(1'b1, 1'b1, SAC_ADDR_WINDOW, 16'ha5a5);
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk(o_rdata, 16'h5a5a);
        op(1'b1, 1'b0, 8'h43, 16'hffff);
        rd_chk(8'h43, 16'h0000);
        rd_chk(SAC_ADDR_WINDOW, 16'ha5a5);
        rd_chk(SAC_ADDR_FRONTEND, 16'hfff3);
        @(posedge i_clk);
        i_ext_chan_gain <= 6'h2d;
        op(1'b1, 1'b0, SAC_ADDR_FRONTEND, 16'h1c42);
        repeat (2) op(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk({8'h00, o_cfg.chan_gain}, 16'h00b6);
        // Channel 2-4 gains pass through one edge after they change
        @(posedge i_clk);
        i_ext_chan_gain <= 6'h12;
        op(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk({8'h00, o_cfg.chan_gain}, 16'h004a);
        // With individual gains off, the channel 1 code feeds all four
        op(1'b1, 1'b0, SAC_ADDR_FRONTEND, 16'h1c31);
        repeat (2) op(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk({8'h00, o_cfg.chan_gain}, 16'h0055);
        // Second reset in mid-run
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        reset_chk();
        tally_and_finish();
    end
endmodule // test_sac_regs
`default_nettype wire
